// File: dtmc_pkg.sv
// Purpose: Constants for the DRAM timing and mode control block
// Assumes: core_clk is the command clock, one per two DDR transfers
// Notes:   Tables pack four 4-bit entries, entry n at bits 4n+3:4n
package dtmc_pkg;

  // Register map, byte addresses on APB
  localparam logic [11:0] TIMING_OFFSET = 12'h078;
  localparam logic [11:0] MODE_OFFSET   = 12'h07C;
  localparam logic [11:0] STATUS_OFFSET = 12'h0F0;

  localparam logic [31:0] TIMING_RESET  = 32'h0000_0014;
  localparam logic [31:0] TIMING_WMASK  = 32'h0000_033F;
  localparam logic [31:0] MODE_RESET    = 32'h0000_0000;
  localparam logic [31:0] MODE_WMASK    = 32'h3E00_6FC8;
  // Bits a configuration restore may reload
  localparam logic [31:0] MODE_RESTORE  = 32'h2E00_68C0;

  // Timing register fields
  localparam int TRP_LSB  = 8;
  localparam int READ_ROUND_TRIP_LATENCY_LSB = 4;
  localparam int CAS_LSB  = 2;
  localparam int WTT_LSB  = 0;

  // Mode register fields
  localparam int INIT_BIT  = 29;
  localparam int CKE_BIT   = 28;
  localparam int SRI_BIT   = 27;
  localparam int OVL_BIT   = 26;
  localparam int EXT_BIT   = 25;
  localparam int ODT_LSB   = 13;
  localparam int DIFF_BIT  = 11;
  localparam int RMS_LSB   = 8;
  localparam int FPR_BIT   = 7;
  localparam int HG_BIT    = 6;
  localparam int SPARE_BIT = 3;

  localparam logic [1:0] ODT_75_OHM = 2'h3;

  // Frequency setting codes
  localparam logic [1:0] FREQ_266 = 2'h0;
  localparam logic [1:0] FREQ_333 = 2'h2;
  localparam logic [1:0] FREQ_400 = 2'h3;

  // Gap tables in command clocks; reserved entries hold the safest value
  localparam logic [15:0] TRP_266_333   = 16'h4324;
  localparam logic [15:0] TRP_400       = 16'h4344;
  // Latency tables in half clocks; write turnaround tables in command clocks
  localparam logic [15:0] READ_ROUND_TRIP_LATENCY_266      = 16'h7465;
  localparam logic [15:0] READ_ROUND_TRIP_LATENCY_333      = 16'hA864;
  localparam logic [15:0] READ_ROUND_TRIP_LATENCY_400      = 16'hA486;
  localparam logic [15:0] CAS_266_333   = 16'h8854;
  localparam logic [15:0] CAS_400       = 16'h8868;
  localparam logic [15:0] WTT_LO_XRANK  = 16'h2210;
  localparam logic [15:0] WTT_LO_SAME   = 16'h4210;
  localparam logic [15:0] WTT_400       = 16'h0310;

  // Refresh select codes
  localparam logic [2:0] RMS_OFF   = 3'h0;
  localparam logic [2:0] RMS_15_6  = 3'h1;
  localparam logic [2:0] RMS_7_8   = 3'h2;
  localparam logic [2:0] RMS_64    = 3'h3;
  localparam logic [2:0] RMS_FREQ  = 3'h4;
  localparam logic [2:0] RMS_FAST  = 3'h7;

  localparam int CLK_PERIOD_NS  = 10;
  localparam int REF_15_6_NS    = 15600;
  localparam int REF_7_8_NS     = 7800;
  localparam int REF_64_NS      = 64000;
  // Longest intervals, so counts round down
  localparam logic [12:0] REF_15_6_CLKS = 13'(REF_15_6_NS / CLK_PERIOD_NS);
  localparam logic [12:0] REF_7_8_CLKS  = 13'(REF_7_8_NS / CLK_PERIOD_NS);
  localparam logic [12:0] REF_266_CLKS  = 13'd728;
  localparam logic [12:0] REF_333_CLKS  = 13'd1092;
  localparam logic [12:0] REF_400_CLKS  = 13'd1456;
  localparam logic [12:0] REF_FAST_CLKS = 13'd64;

  localparam logic [3:0] BURST_CLKS      = 4'h2;
  localparam logic [3:0] ACT_TO_COL_CLKS = 4'h2;
  localparam logic [3:0] CNT_MAX         = 4'hF;

  typedef enum logic [1:0] {
    CMD_ACT,
    CMD_RD,
    CMD_WR,
    CMD_PRE
  } dtmc_cmd_e;

endpackage

// File: dtmc_top.sv
// Purpose: Timing and mode control for a DDR/DDR2 DIMM controller
// Assumes: APB slave, core_clk is the command clock
// Notes:   Commands are granted one at a time against the gap counters
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module dtmc_top #(
  parameter logic [12:0] REF_64_CLKS =
    13'(dtmc_pkg::REF_64_NS / dtmc_pkg::CLK_PERIOD_NS)
) (
  input  wire logic                core_clk,
  input  wire logic                reset_n,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic [1:0]          memory_freq_setting,
  input  wire logic                cmd_req,
  input  wire dtmc_pkg::dtmc_cmd_e cmd_kind,
  input  wire logic [1:0]          cmd_rank,
  output logic                     cmd_grant,
  output logic                     read_capture,
  output logic                     fifo_ptr_reset,
  output logic                     refresh_due,
  input  wire logic                reset_entry,
  output logic                     self_refresh_entry,
  output logic                     power_down_entry,
  input  wire logic                config_restore,
  input  wire logic [31:0]         config_restore_data,
  output logic                     dram_cke,
  output logic                     strobe_complement_oe,
  output logic                     strobe_rx_diff_sel,
  output logic                     strobe_half_gain,
  output logic      [1:0]          termination_strength,
  output logic                     sparing_en
);

  logic [31:0]         timing;
  logic [31:0]         mode;
  logic [3:0]          pre_cnt;
  logic [3:0]          act_cnt;
  logic [3:0]          wr_cnt;
  logic [3:0]          col_busy;
  logic [15:0]         rd_pipe;
  logic [1:0]          last_wr_rank;
  logic [12:0]         ref_cnt;
  dtmc_pkg::dtmc_cmd_e granted_kind;

  logic                acc;
  logic                wr_timing;
  logic                wr_mode;
  logic                next_grant;
  logic                allow;
  logic [3:0]          trp_clks;
  logic [4:0]          rd_half;
  logic [3:0]          rd_lat;
  logic [3:0]          wtt_gap;
  logic [3:0]          wr_space;
  logic [3:0]          act_need;
  logic [12:0]         ref_interval;
  logic [31:0]         rd_value;
  logic                mapped;

  function automatic logic [3:0] tbl(input logic [15:0] t,
                                     input logic [1:0]  code);
    tbl = t[{code, 2'h0} +: 4];
  endfunction

  // Termination field keeps its value unless the 75 ohm code arrives
  function automatic logic [31:0] merge_mode(input logic [31:0] old,
                                             input logic [31:0] data,
                                             input logic [31:0] mask);
    logic [31:0] m;
    m = (old & ~mask) | (data & mask);
    if (data[dtmc_pkg::ODT_LSB +: 2] != dtmc_pkg::ODT_75_OHM) begin
      m[dtmc_pkg::ODT_LSB +: 2] = old[dtmc_pkg::ODT_LSB +: 2];
    end
    merge_mode = m;
  endfunction

  // APB: one wait state, writes land on the edge that samples pready
  assign acc       = psel && penable && pready;
  assign wr_timing = acc && pwrite && (paddr == dtmc_pkg::TIMING_OFFSET);
  assign wr_mode   = acc && pwrite && (paddr == dtmc_pkg::MODE_OFFSET);
  assign mapped    = (paddr == dtmc_pkg::TIMING_OFFSET) ||
                     (paddr == dtmc_pkg::MODE_OFFSET) ||
                     (paddr == dtmc_pkg::STATUS_OFFSET);

  always_comb begin
    rd_value = 32'h0000_0000;
    case (paddr)
      dtmc_pkg::TIMING_OFFSET: rd_value = timing;
      dtmc_pkg::MODE_OFFSET:   rd_value = mode;
      dtmc_pkg::STATUS_OFFSET: rd_value = {3'h0, ref_cnt, 14'h0000,
                                           col_busy != 4'h0,
                                           rd_pipe != 16'h0000};
      default:                 rd_value = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      if (psel && penable && !pready) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_value;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      timing <= dtmc_pkg::TIMING_RESET;
    end else if (wr_timing) begin
      timing <= (timing & ~dtmc_pkg::TIMING_WMASK) |
                (pwdata & dtmc_pkg::TIMING_WMASK);
    end
  end

  // Scratch bit is stored and read back only, it steers nothing
  // Restore skips CKE, refresh select and sparing
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      mode <= dtmc_pkg::MODE_RESET;
    end else if (wr_mode) begin
      mode <= merge_mode(mode, pwdata, dtmc_pkg::MODE_WMASK);
    end else if (config_restore) begin
      mode <= merge_mode(mode, config_restore_data,
                         dtmc_pkg::MODE_RESTORE);
    end
  end

  assign dram_cke             = mode[dtmc_pkg::CKE_BIT];
  assign strobe_complement_oe = mode[dtmc_pkg::DIFF_BIT];
  assign strobe_rx_diff_sel   = mode[dtmc_pkg::DIFF_BIT];
  assign strobe_half_gain     = mode[dtmc_pkg::HG_BIT];
  assign termination_strength = mode[dtmc_pkg::ODT_LSB +: 2];
  assign sparing_en           = mode[dtmc_pkg::SPARE_BIT];

  // Per-frequency table columns; gaps are in command clocks
  always_comb begin
    if (memory_freq_setting == dtmc_pkg::FREQ_400) begin
      trp_clks = tbl(dtmc_pkg::TRP_400, timing[dtmc_pkg::TRP_LSB +: 2]);
      rd_half  = {1'b0, tbl(dtmc_pkg::READ_ROUND_TRIP_LATENCY_400,
                            timing[dtmc_pkg::READ_ROUND_TRIP_LATENCY_LSB +: 2])} +
                 {1'b0, tbl(dtmc_pkg::CAS_400,
                            timing[dtmc_pkg::CAS_LSB +: 2])};
      wtt_gap  = tbl(dtmc_pkg::WTT_400, timing[dtmc_pkg::WTT_LSB +: 2]);
    end else begin
      trp_clks = tbl(dtmc_pkg::TRP_266_333,
                     timing[dtmc_pkg::TRP_LSB +: 2]);
      rd_half  = {1'b0, tbl((memory_freq_setting == dtmc_pkg::FREQ_333) ?
                            dtmc_pkg::READ_ROUND_TRIP_LATENCY_333 : dtmc_pkg::READ_ROUND_TRIP_LATENCY_266,
                            timing[dtmc_pkg::READ_ROUND_TRIP_LATENCY_LSB +: 2])} +
                 {1'b0, tbl(dtmc_pkg::CAS_266_333,
                            timing[dtmc_pkg::CAS_LSB +: 2])};
      // Code 11: longer gap back to the same rank
      wtt_gap  = tbl((cmd_rank == last_wr_rank) ? dtmc_pkg::WTT_LO_SAME :
                     dtmc_pkg::WTT_LO_XRANK,
                     timing[dtmc_pkg::WTT_LSB +: 2]);
    end
  end

  // Half clocks round up so data is never sampled early
  assign rd_lat = 4'((rd_half + 5'h01) >> 1);

  // Gap 0 or 1 both mean bursts abut; more adds idle clocks
  assign wr_space = (wtt_gap == 4'h0) ? dtmc_pkg::BURST_CLKS :
                    4'(dtmc_pkg::BURST_CLKS + wtt_gap - 4'h1);

  // Stretch only while the data bus is busy anyway, costing nothing
  assign act_need = dtmc_pkg::ACT_TO_COL_CLKS +
                    {3'h0, !mode[dtmc_pkg::EXT_BIT] &&
                           (col_busy != 4'h0)};

  always_comb begin
    allow = 1'b0;
    case (cmd_kind)
      dtmc_pkg::CMD_ACT: allow = (pre_cnt >= trp_clks) &&
                                 (mode[dtmc_pkg::OVL_BIT] ||
                                  col_busy == 4'h0);
      dtmc_pkg::CMD_RD:  allow = act_cnt >= act_need;
      dtmc_pkg::CMD_WR:  allow = (act_cnt >= act_need) &&
                                 (wr_cnt >= wr_space);
      dtmc_pkg::CMD_PRE: allow = 1'b1;
      default:           allow = 1'b0;
    endcase
  end

  // No commands while CKE is low
  assign next_grant = cmd_req && allow && dram_cke && !cmd_grant;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cmd_grant    <= 1'b0;
      granted_kind <= dtmc_pkg::CMD_ACT;
      last_wr_rank <= 2'h0;
    end else begin
      cmd_grant <= next_grant;
      if (next_grant) begin
        granted_kind <= cmd_kind;
      end
      if (next_grant && cmd_kind == dtmc_pkg::CMD_WR) begin
        last_wr_rank <= cmd_rank;
      end
    end
  end

  // Saturating counts of clocks since the last precharge, activate and write
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pre_cnt <= dtmc_pkg::CNT_MAX;
      act_cnt <= dtmc_pkg::CNT_MAX;
      wr_cnt  <= dtmc_pkg::CNT_MAX;
    end else begin
      if (next_grant && cmd_kind == dtmc_pkg::CMD_PRE) begin
        pre_cnt <= 4'h1;
      end else if (pre_cnt != dtmc_pkg::CNT_MAX) begin
        pre_cnt <= pre_cnt + 4'h1;
      end
      if (next_grant && cmd_kind == dtmc_pkg::CMD_ACT) begin
        act_cnt <= 4'h1;
      end else if (act_cnt != dtmc_pkg::CNT_MAX) begin
        act_cnt <= act_cnt + 4'h1;
      end
      if (next_grant && cmd_kind == dtmc_pkg::CMD_WR) begin
        wr_cnt <= 4'h1;
      end else if (wr_cnt != dtmc_pkg::CNT_MAX) begin
        wr_cnt <= wr_cnt + 4'h1;
      end
    end
  end

  // Clocks until the last column command leaves the data bus
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      col_busy <= 4'h0;
    end else if (next_grant && cmd_kind == dtmc_pkg::CMD_RD) begin
      col_busy <= 4'(rd_lat + dtmc_pkg::BURST_CLKS);
    end else if (next_grant && cmd_kind == dtmc_pkg::CMD_WR) begin
      col_busy <= dtmc_pkg::BURST_CLKS;
    end else if (col_busy != 4'h0) begin
      col_busy <= col_busy - 4'h1;
    end
  end

  // One bit per read in flight, reaching bit 0 one clock before read_capture
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rd_pipe        <= 16'h0000;
      read_capture   <= 1'b0;
      fifo_ptr_reset <= 1'b0;
    end else begin
      rd_pipe <= {1'b0, rd_pipe[15:1]} |
                 ((next_grant && cmd_kind == dtmc_pkg::CMD_RD) ?
                  (16'h0001 << (rd_lat - 4'h1)) : 16'h0000);
      read_capture   <= rd_pipe[0];
      fifo_ptr_reset <= rd_pipe[0] && (rd_pipe[15:1] == 15'h0000) &&
                        !(next_grant && cmd_kind == dtmc_pkg::CMD_RD) &&
                        !mode[dtmc_pkg::FPR_BIT];
    end
  end

  always_comb begin
    case (mode[dtmc_pkg::RMS_LSB +: 3])
      dtmc_pkg::RMS_15_6: ref_interval = dtmc_pkg::REF_15_6_CLKS;
      dtmc_pkg::RMS_7_8:  ref_interval = dtmc_pkg::REF_7_8_CLKS;
      dtmc_pkg::RMS_64:   ref_interval = REF_64_CLKS;
      dtmc_pkg::RMS_FREQ: begin
        if (memory_freq_setting == dtmc_pkg::FREQ_400) begin
          ref_interval = dtmc_pkg::REF_400_CLKS;
        end else if (memory_freq_setting == dtmc_pkg::FREQ_333) begin
          ref_interval = dtmc_pkg::REF_333_CLKS;
        end else begin
          ref_interval = dtmc_pkg::REF_266_CLKS;
        end
      end
      dtmc_pkg::RMS_FAST: ref_interval = dtmc_pkg::REF_FAST_CLKS;
      default:            ref_interval = 13'h0000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ref_cnt     <= 13'h0000;
      refresh_due <= 1'b0;
    end else if (wr_mode && pwdata[dtmc_pkg::RMS_LSB +: 3] ==
                 dtmc_pkg::RMS_OFF) begin
      ref_cnt     <= 13'h0000;
      refresh_due <= 1'b0;
    end else if (ref_interval == 13'h0000) begin
      refresh_due <= 1'b0;
    end else if (ref_cnt >= ref_interval - 13'h0001) begin
      ref_cnt     <= 13'h0000;
      refresh_due <= 1'b1;
    end else begin
      ref_cnt     <= ref_cnt + 13'h0001;
      refresh_due <= 1'b0;
    end
  end

  // One-clock pulses after reset_entry; the SRI bit picks power down, else self refresh
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      self_refresh_entry <= 1'b0;
      power_down_entry   <= 1'b0;
    end else begin
      self_refresh_entry <= reset_entry && !mode[dtmc_pkg::SRI_BIT];
      power_down_entry   <= reset_entry && mode[dtmc_pkg::SRI_BIT];
    end
  end

  cke_follow_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    wr_mode ##1 1'b1 |-> dram_cke == $past(pwdata[dtmc_pkg::CKE_BIT]))
    else $error("CKE does not follow written bit");

  pre_act_gap_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (cmd_grant && granted_kind == dtmc_pkg::CMD_ACT) |->
      $past(pre_cnt) >= $past(trp_clks))
    else $error("Activate granted inside precharge gap");

  wr_spacing_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (cmd_grant && granted_kind == dtmc_pkg::CMD_WR) |->
      $past(wr_cnt) >= $past(wr_space))
    else $error("Write bursts closer than turnaround gap");

  rd_capture_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (cmd_grant && granted_kind == dtmc_pkg::CMD_RD) |-> ##[1:9] read_capture)
    else $error("Read capture missing after read");

  fast_refresh_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (refresh_due && mode[dtmc_pkg::RMS_LSB +: 3] == dtmc_pkg::RMS_FAST &&
     !wr_mode) |=> !refresh_due [*8])
    else $error("Fast refresh pulses too close");

  refresh_clear_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (wr_mode && pwdata[dtmc_pkg::RMS_LSB +: 3] == dtmc_pkg::RMS_OFF) |=>
      (ref_cnt == 13'h0000 && !refresh_due) [*2])
    else $error("Refresh counter not cleared");

  overlap_gate_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (cmd_grant && granted_kind == dtmc_pkg::CMD_ACT &&
     !$past(mode[dtmc_pkg::OVL_BIT])) |-> $past(col_busy) == 4'h0)
    else $error("Activate overlapped column command");

  odt_legal_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    $changed(termination_strength) |-> termination_strength ==
      dtmc_pkg::ODT_75_OHM)
    else $error("Reserved termination code accepted");

  srpd_select_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    reset_entry |=> (power_down_entry == $past(mode[dtmc_pkg::SRI_BIT])) &&
      (self_refresh_entry != power_down_entry))
    else $error("Wrong low-power entry at reset");

  fifo_inhibit_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    fifo_ptr_reset |-> $past(read_capture == 1'b0 && rd_pipe[0]) &&
      !$past(mode[dtmc_pkg::FPR_BIT]))
    else $error("FIFO pointer reset while inhibited");

endmodule
`default_nettype wire

// File: dtmc_dimm_model.sv
// Purpose: DIMM-side view of the commands the block grants
// Assumes: command seen in the cycle its grant is high
// Notes:   Gaps are grant-to-grant distances in command clocks
`timescale 1ns/1ps
`default_nettype none
module dtmc_dimm_model (
  input  wire logic                core_clk,
  input  wire logic                reset_n,
  input  wire logic                cmd_grant,
  input  wire dtmc_pkg::dtmc_cmd_e cmd_kind,
  input  wire logic                dram_cke,
  output var  int                  act_gap,
  output var  int                  wr_gap,
  output var  int                  cke_faults
);
  int cyc = 0;
  int pre_cyc = 0;
  int wr_cyc = 0;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (!reset_n) begin
      cke_faults <= 0;
    end else if (cmd_grant) begin
      // DRAM ignores commands while its clock enable is low
      if (!dram_cke) cke_faults <= cke_faults + 1;
      case (cmd_kind)
        dtmc_pkg::CMD_PRE: pre_cyc <= cyc;
        dtmc_pkg::CMD_ACT: act_gap <= cyc - pre_cyc;
        dtmc_pkg::CMD_WR: begin
          wr_gap <= cyc - wr_cyc;
          wr_cyc <= cyc;
        end
        default: ;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: testbench.sv
// Purpose: Self-checking bench for the timing and mode block
// Assumes: APB with one wait state, 100 MHz command clock
// Notes:   Short 64 us refresh count keeps the run brief
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        core_clk, reset_n, psel, penable, pwrite, serr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, v, config_restore_data;
  logic        pready, pslverr, cmd_req, cmd_grant, read_capture;
  logic        fifo_ptr_reset, refresh_due, reset_entry, config_restore;
  logic        self_refresh_entry, power_down_entry, dram_cke, sparing_en;
  logic        strobe_complement_oe, strobe_rx_diff_sel, strobe_half_gain;
  logic [1:0]  memory_freq_setting, cmd_rank, termination_strength, g, r;
  dtmc_pkg::dtmc_cmd_e cmd_kind;
  int          err_total, samples_checked, act_gap, wr_gap, cke_faults;
  int          m, i;
  // CKE on, overlap on, stretch off, 75 ohm termination
  localparam logic [31:0] BASE = 32'h1600_6000;
  localparam logic [11:0] TIM = dtmc_pkg::TIMING_OFFSET;
  localparam logic [11:0] MOD = dtmc_pkg::MODE_OFFSET;

  dtmc_top #(.REF_64_CLKS(13'd100)) u_dtmc_top (
    .core_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .memory_freq_setting, .cmd_req,
    .cmd_kind, .cmd_rank, .cmd_grant, .read_capture, .fifo_ptr_reset,
    .refresh_due, .reset_entry, .self_refresh_entry, .power_down_entry,
    .config_restore, .config_restore_data, .dram_cke,
    .strobe_complement_oe, .strobe_rx_diff_sel, .strobe_half_gain,
    .termination_strength, .sparing_en);
  dtmc_dimm_model u_dtmc_dimm_model (
    .core_clk, .reset_n, .cmd_grant, .cmd_kind, .dram_cke, .act_gap,
    .wr_gap, .cke_faults);

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd      = prdata;
    serr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_on(ref logic s, output int n);
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (s !== 1'b1 && n < 2000);
  endtask

  // Second request follows the first grant with no idle cycle
  task automatic cmd2(input dtmc_pkg::dtmc_cmd_e k1, k2,
                      input logic [1:0] r1, r2);
    @(posedge core_clk);
    cmd_req  <= 1'b1;
    cmd_kind <= k1;
    cmd_rank <= r1;
    wait_on(cmd_grant, m);
    cmd_kind <= k2;
    cmd_rank <= r2;
    wait_on(cmd_grant, m);
    cmd_req <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask

  // Whole clocks from grant to capture at 266, half steps rounded up
  function automatic int rd_lat(input logic [1:0] cas, rrl);
    int ch;
    int rh;
    ch = (cas == 2'h0) ? 4 : 5;
    rh = (rrl == 2'h0) ? 5 : (rrl == 2'h1) ? 6 : (rrl == 2'h2) ? 4 : 7;
    return (ch + rh + 1) / 2;
  endfunction

  function automatic int wr_exp(input logic [1:0] c, input logic same);
    if (c == 2'h2) return 3;
    if (c == 2'h3) return same ? 5 : 3;
    return 2;
  endfunction

  initial begin
    repeat (40000) @(posedge core_clk);
    err_total++;
    final_report();
  end

  initial begin
    {psel, penable, pwrite, cmd_req, reset_entry, config_restore} = '0;
    {paddr, pwdata, cmd_rank, config_restore_data} = '0;
    cmd_kind = dtmc_pkg::CMD_ACT;
    memory_freq_setting = dtmc_pkg::FREQ_266;
    err_total = 0;
    samples_checked = 0;
    reset_n = 1'b0;
    void'($urandom(32'hA651));
    repeat (20) @(posedge core_clk);
    reset_n <= 1'b1;
    apb(1'b0, TIM, 32'h0);
    chk(rd, dtmc_pkg::TIMING_RESET);
    apb(1'b0, MOD, 32'h0);
    chk(rd, dtmc_pkg::MODE_RESET);
    apb(1'b1, 12'h080, 32'hFFFF_FFFF);
    apb(1'b0, 12'h080, 32'h0);
    chk(32'(serr), 32'h1);
    chk(rd, 32'h0);
    v = $urandom();
    apb(1'b1, TIM, v);
    apb(1'b0, TIM, 32'h0);
    chk(rd, v & dtmc_pkg::TIMING_WMASK);
    repeat (4) begin
      v = $urandom() | 32'h0000_6000;
      apb(1'b1, MOD, v);
      apb(1'b0, MOD, 32'h0);
      chk(rd, v & dtmc_pkg::MODE_WMASK);
      chk(32'(dram_cke), 32'(v[28]));
      chk(32'(strobe_complement_oe), 32'(v[11]));
      chk(32'(strobe_rx_diff_sel), 32'(v[11]));
      chk(32'(strobe_half_gain), 32'(v[6]));
      chk(32'(sparing_en), 32'(v[3]));
      apb(1'b1, MOD, $urandom() & 32'hFFFF_BFFF);
      apb(1'b0, MOD, 32'h0);
      chk(32'(rd[14:13]), 32'h3);
      chk(32'(termination_strength), 32'h3);
    end
    for (i = 0; i < 5; i++) begin
      apb(1'b1, MOD, BASE | ((i == 4) ? 32'h80 : 32'h0));
      g = (i == 3) ? 2'h0 : 2'h1;
      apb(1'b1, TIM, {26'h0, 2'(i), g, 2'h0});
      @(posedge core_clk);
      cmd_req  <= 1'b1;
      cmd_kind <= dtmc_pkg::CMD_RD;
      wait_on(cmd_grant, m);
      cmd_req <= 1'b0;
      wait_on(read_capture, m);
      chk(32'(m), 32'(rd_lat(g, 2'(i))));
      chk(32'(fifo_ptr_reset), 32'(i != 4));
    end
    apb(1'b1, MOD, BASE);
    for (i = 0; i < 9; i++) begin
      g = (i == 8) ? 2'h3 : 2'(i >> 1);
      memory_freq_setting <= (i == 8) ? dtmc_pkg::FREQ_400
                                      : dtmc_pkg::FREQ_266;
      apb(1'b1, TIM, 32'h14 | 32'(g));
      r = 2'($urandom());
      cmd2(dtmc_pkg::CMD_WR, dtmc_pkg::CMD_WR, r, i[0] ? r : ~r);
      chk(32'(wr_gap), (i == 8) ? 2 : wr_exp(g, i[0]));
    end
    for (i = 0; i < 3; i++) begin
      memory_freq_setting <= (i == 2) ? dtmc_pkg::FREQ_400
                                      : dtmc_pkg::FREQ_266;
      apb(1'b1, MOD, (i == 1) ? BASE & ~32'h0400_0000 : BASE);
      apb(1'b1, TIM, 32'h14 | (32'(i + 1) << 8));
      cmd2(dtmc_pkg::CMD_PRE, dtmc_pkg::CMD_ACT, 2'h0, 2'h0);
      chk(32'(act_gap), 32'(i + 2));
    end
    memory_freq_setting <= dtmc_pkg::FREQ_266;
    for (i = 0; i < 5; i++) begin
      g = 2'h0;
      apb(1'b1, MOD, BASE | (32'(i == 4 ? 7 : i + 1) << 8));
      wait_on(refresh_due, m);
      wait_on(refresh_due, m);
      chk(32'(m), (i == 0) ? 1560 : (i == 1) ? 780 : (i == 2) ? 100
                  : (i == 3) ? 728 : 64);
    end
    apb(1'b1, MOD, BASE);
    m = 0;
    repeat (2000) begin
      @(posedge core_clk);
      if (refresh_due === 1'b1) m++;
    end
    chk(32'(m), 32'h0);
    for (i = 0; i < 2; i++) begin
      apb(1'b1, MOD, BASE | (32'(i) << 27));
      reset_entry <= 1'b1;
      @(posedge core_clk);
      reset_entry <= 1'b0;
      @(posedge core_clk);
      chk(32'(power_down_entry), 32'(i));
      chk(32'(self_refresh_entry), 32'(i == 0));
    end
    apb(1'b1, MOD, BASE);
    config_restore      <= 1'b1;
    config_restore_data <= 32'hEFFF_FFFF;
    @(posedge core_clk);
    config_restore <= 1'b0;
    apb(1'b0, MOD, 32'h0);
    chk(rd, BASE | dtmc_pkg::MODE_RESTORE);
    chk(32'(dram_cke), 32'h1);
    chk(32'(sparing_en), 32'h0);
    chk(32'(cke_faults), 32'h0);
    final_report();
  end
endmodule
`default_nettype wire
